// ==== verilog/mfi_irq_service.sv ====
// Local design decisions: the register addresses and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
module mfi_irq_service #(
   parameter int TEMP_LATCH_CYCLES = mfi_pkg::TEMP_LATCH_CYC
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        software_reset,
   // Avalon-MM slave
   input  wire logic [7:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   // Motion engine conditions, levels
   input  wire logic        tilt_cond,
   input  wire logic        flip_cond,
   input  wire logic        generic_movement_cond,
   input  wire logic        shake_cond,
   input  wire logic        steep_tilt_cond,
   input  wire logic        motion_hw_clear,
   // Sample path pulses
   input  wire logic        z_process_done,
   input  wire logic        z_accum_start,
   input  wire logic        wake_state,
   input  wire logic        sample_write,
   input  wire logic [7:0]  sample_data,
   // Interrupt requests
   output logic             primary_irq_request,
   output logic             secondary_irq_request
);

   logic        rst;
   logic [5:0]  idx;
   logic        rd_ack_ff;
   logic        wr_ok;
   logic        rd_take;
   logic        status_wr;

   logic [7:0]  int_enable_ff;
   logic [7:0]  motion_ctrl_ff;
   logic [7:0]  queue_ctrl_ff;
   logic [5:0]  queue_level_ff;
   logic [7:0]  service_ctrl_ff;
   logic [1:0]  mode;
   logic        indiv;

   logic [4:0]  cond_now;
   logic [4:0]  cond_prev_ff;
   logic [7:0]  motion_en;
   logic [7:0]  set_v;
   logic [7:0]  clr_v;
   logic [7:0]  status_ff;
   logic [7:0]  nxt_status;

   logic [31:0] temp_cnt_ff;
   logic        temp_timeout;

   logic [7:0]  queue_mem [0:31];
   logic [4:0]  wr_ptr_ff;
   logic [4:0]  rd_ptr_ff;
   logic [5:0]  count_ff;
   logic [5:0]  nxt_count;
   logic        push;
   logic        pop;
   logic        q_access;
   logic [2:0]  qflag_ff;
   logic [2:0]  nxt_qflag;
   logic [2:0]  qirq_ff;
   logic [2:0]  qirq_set;
   logic        qirq_clr;

   // Software reset acts exactly like the bus reset
   assign rst = reset | software_reset;
   assign idx = address[7:2];

   function automatic logic [5:0] step_count(input logic [5:0] cnt, input logic inc, input logic dec);
      logic [5:0] r;
      r = cnt;
      if (inc && !dec)
      begin
         r = cnt + 6'h01;
      end
      else if (dec && !inc)
      begin
         r = cnt - 6'h01;
      end
      return r;
   endfunction : step_count

   // Bus handshake: reads take one wait cycle so read data comes from flops
   assign waitrequest = read & ~rd_ack_ff;
   assign wr_ok       = write & byteenable[0];
   assign rd_take     = read & ~rd_ack_ff;
   assign status_wr   = wr_ok && (idx == mfi_pkg::IDX_INT_STATUS);

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rd_ack_ff <= 1'b0;
      end
      else
      begin
         rd_ack_ff <= rd_take;
      end
   end

   // Software-written control registers
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         int_enable_ff   <= mfi_pkg::RST_INT_ENABLE;
         motion_ctrl_ff  <= mfi_pkg::RST_MOTION_CTRL;
         queue_ctrl_ff   <= mfi_pkg::RST_QUEUE_CTRL;
         queue_level_ff  <= mfi_pkg::RST_QUEUE_LEVEL;
         service_ctrl_ff <= mfi_pkg::RST_SERVICE_CTRL;
      end
      else if (wr_ok)
      begin
         if (idx == mfi_pkg::IDX_INT_ENABLE)
         begin
            int_enable_ff <= writedata[7:0];
         end
         else if (idx == mfi_pkg::IDX_MOTION_CTRL)
         begin
            motion_ctrl_ff <= writedata[7:0];
         end
         else if (idx == mfi_pkg::IDX_QUEUE_CTRL)
         begin
            queue_ctrl_ff <= writedata[7:0];
         end
         else if (idx == mfi_pkg::IDX_QUEUE_LEVEL)
         begin
            queue_level_ff <= writedata[5:0];
         end
         else if (idx == mfi_pkg::IDX_SERVICE_CTRL)
         begin
            service_ctrl_ff <= writedata[7:0];
         end
      end
   end

   assign mode  = service_ctrl_ff[mfi_pkg::BIT_MODE_LO +: 2];
   assign indiv = service_ctrl_ff[mfi_pkg::BIT_INDIV_CLEAR];

   // Motion sources: feature gating in motion control
   assign cond_now = {steep_tilt_cond, shake_cond, generic_movement_cond, flip_cond, tilt_cond};

   always_comb
   begin
      motion_en = 8'h00;
      motion_en[mfi_pkg::BIT_TILT_FLIP]  = motion_ctrl_ff[mfi_pkg::BIT_TILT_FLIP];
      motion_en[mfi_pkg::BIT_FLIP]       = motion_ctrl_ff[mfi_pkg::BIT_TILT_FLIP];
      motion_en[mfi_pkg::BIT_GENERIC]    = motion_ctrl_ff[mfi_pkg::BIT_GENERIC];
      motion_en[mfi_pkg::BIT_SHAKE]      = motion_ctrl_ff[mfi_pkg::BIT_SHAKE]
                                         & motion_ctrl_ff[mfi_pkg::BIT_GENERIC];
      motion_en[mfi_pkg::BIT_STEEP_TILT] = motion_ctrl_ff[mfi_pkg::BIT_STEEP_TILT]
                                         & motion_ctrl_ff[mfi_pkg::BIT_GENERIC];
      motion_en[mfi_pkg::BIT_SAMPLE]     = 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cond_prev_ff <= 5'h00;
      end
      else
      begin
         cond_prev_ff <= cond_now;
      end
   end

   // Set on condition onset; shake and steep tilt need no generic irq enable
   always_comb
   begin
      set_v = 8'h00;
      set_v[4:0] = cond_now & ~cond_prev_ff & motion_en[4:0] & int_enable_ff[4:0];
      set_v[mfi_pkg::BIT_SAMPLE] = z_process_done & int_enable_ff[mfi_pkg::BIT_SAMPLE];
   end

   // Clear sources per servicing mode
   always_comb
   begin
      clr_v = 8'h00;
      if (status_wr)
      begin
         if (indiv)
         begin
            clr_v = writedata[7:0];
         end
         else
         begin
            clr_v = 8'hff;
         end
      end
      if (mode == mfi_pkg::MODE_TEMP && temp_timeout)
      begin
         clr_v = 8'hff;
      end
      else if (mode == mfi_pkg::MODE_AUTO)
      begin
         clr_v[4:0] = clr_v[4:0] | ~cond_now | {5{motion_hw_clear}};
         clr_v[mfi_pkg::BIT_SAMPLE] = clr_v[mfi_pkg::BIT_SAMPLE] | z_accum_start;
      end
   end

   // A set in the same cycle as a clear wins
   always_comb
   begin
      nxt_status = (status_ff & ~clr_v) | set_v;
      nxt_status[mfi_pkg::BIT_QUEUE_CLEAR] = 1'b0;
      nxt_status[6] = 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         status_ff <= 8'h00;
      end
      else
      begin
         status_ff <= nxt_status;
      end
   end

   // One shared temporary latch timer, restarted by every new event
   assign temp_timeout = (temp_cnt_ff == TEMP_LATCH_CYCLES - 1);

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         temp_cnt_ff <= 32'h0000_0000;
      end
      else if (mode != mfi_pkg::MODE_TEMP || status_ff == 8'h00 || set_v != 8'h00 || temp_timeout)
      begin
         temp_cnt_ff <= 32'h0000_0000;
      end
      else
      begin
         temp_cnt_ff <= temp_cnt_ff + 32'h0000_0001;
      end
   end

   // Sample queue; only occupancy matters to the flags
   assign push      = sample_write & wake_state & queue_ctrl_ff[mfi_pkg::BIT_Q_ENABLE]
                    & (count_ff != mfi_pkg::QUEUE_DEPTH);
   assign pop       = rd_take && (idx == mfi_pkg::IDX_QUEUE_DATA) && (count_ff != 6'h00)
                    && queue_ctrl_ff[mfi_pkg::BIT_Q_ENABLE];
   assign q_access  = push | pop;
   assign nxt_count = step_count(count_ff, push, pop);

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         queue_mem[wr_ptr_ff] <= sample_data;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wr_ptr_ff <= 5'h00;
         rd_ptr_ff <= 5'h00;
         count_ff  <= 6'h00;
      end
      else
      begin
         wr_ptr_ff <= push ? wr_ptr_ff + 5'h01 : wr_ptr_ff;
         rd_ptr_ff <= pop ? rd_ptr_ff + 5'h01 : rd_ptr_ff;
         count_ff  <= nxt_count;
      end
   end

   // Flags change only on a queue access, and only while the queue is enabled
   always_comb
   begin
      nxt_qflag = qflag_ff;
      if (q_access)
      begin
         nxt_qflag[mfi_pkg::BIT_Q_EMPTY] = (nxt_count == 6'h00);
         nxt_qflag[mfi_pkg::BIT_Q_FULL]  = (nxt_count == mfi_pkg::QUEUE_DEPTH);
         nxt_qflag[mfi_pkg::BIT_Q_LEVEL] = (nxt_count >= queue_level_ff);
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         qflag_ff <= mfi_pkg::RST_QUEUE_FLAGS;
      end
      else
      begin
         qflag_ff <= nxt_qflag;
      end
   end

   // Queue irqs are latched whatever the motion servicing mode
   assign qirq_set = {3{q_access}} & nxt_qflag & queue_ctrl_ff[2:0];
   assign qirq_clr = status_wr && (!indiv || writedata[mfi_pkg::BIT_QUEUE_CLEAR]);

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         qirq_ff <= 3'h0;
      end
      else
      begin
         qirq_ff <= (qirq_ff & ~{3{qirq_clr}}) | qirq_set;
      end
   end

   // Read data
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         readdata <= 32'h0000_0000;
      end
      else if (rd_take)
      begin
         if (idx == mfi_pkg::IDX_INT_ENABLE)
         begin
            readdata <= {24'h00_0000, int_enable_ff};
         end
         else if (idx == mfi_pkg::IDX_MOTION_CTRL)
         begin
            readdata <= {24'h00_0000, motion_ctrl_ff};
         end
         else if (idx == mfi_pkg::IDX_QUEUE_STATUS)
         begin
            readdata <= {29'h0000_0000, qflag_ff};
         end
         else if (idx == mfi_pkg::IDX_QUEUE_DATA)
         begin
            readdata <= {24'h00_0000, (count_ff != 6'h00) ? queue_mem[rd_ptr_ff] : 8'h00};
         end
         else if (idx == mfi_pkg::IDX_INT_STATUS)
         begin
            readdata <= {24'h00_0000, status_ff};
         end
         else if (idx == mfi_pkg::IDX_QUEUE_CTRL)
         begin
            readdata <= {24'h00_0000, queue_ctrl_ff};
         end
         else if (idx == mfi_pkg::IDX_QUEUE_LEVEL)
         begin
            readdata <= {26'h000_0000, queue_level_ff};
         end
         else if (idx == mfi_pkg::IDX_QUEUE_IRQ)
         begin
            readdata <= {29'h0000_0000, qirq_ff};
         end
         else if (idx == mfi_pkg::IDX_SERVICE_CTRL)
         begin
            readdata <= {24'h00_0000, service_ctrl_ff};
         end
         else
         begin
            readdata <= 32'h0000_0000;
         end
      end
   end

   // Requests registered so they never glitch on the pins
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         primary_irq_request   <= 1'b0;
         secondary_irq_request <= 1'b0;
      end
      else
      begin
         primary_irq_request   <= |nxt_status;
         secondary_irq_request <= |((qirq_ff & ~{3{qirq_clr}}) | qirq_set);
      end
   end

endmodule : mfi_irq_service
`default_nettype wire

// ==== verilog/mfi_pkg.sv ====
`default_nettype none
package mfi_pkg;
   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_INT_ENABLE    = 6'h06;
   localparam logic [5:0] IDX_MOTION_CTRL   = 6'h09;
   localparam logic [5:0] IDX_QUEUE_STATUS  = 6'h0a;
   localparam logic [5:0] IDX_QUEUE_DATA    = 6'h0d;
   localparam logic [5:0] IDX_INT_STATUS    = 6'h14;
   localparam logic [5:0] IDX_QUEUE_CTRL    = 6'h2d;
   localparam logic [5:0] IDX_QUEUE_LEVEL   = 6'h2e;
   localparam logic [5:0] IDX_QUEUE_IRQ     = 6'h2f;
   localparam logic [5:0] IDX_SERVICE_CTRL  = 6'h31;

   // Motion control and interrupt status field positions
   localparam int BIT_TILT_FLIP   = 0;
   localparam int BIT_FLIP        = 1;
   localparam int BIT_GENERIC     = 2;
   localparam int BIT_SHAKE       = 3;
   localparam int BIT_STEEP_TILT  = 4;
   localparam int BIT_QUEUE_CLEAR = 5;
   localparam int BIT_SAMPLE      = 7;

   // Queue control, status and service control field positions
   localparam int BIT_Q_EMPTY     = 0;
   localparam int BIT_Q_FULL      = 1;
   localparam int BIT_Q_LEVEL     = 2;
   localparam int BIT_Q_ENABLE    = 5;
   localparam int BIT_INDIV_CLEAR = 6;
   localparam int BIT_MODE_LO     = 0;

   // Servicing modes
   localparam logic [1:0] MODE_LATCHED = 2'h1;
   localparam logic [1:0] MODE_TEMP    = 2'h2;
   localparam logic [1:0] MODE_AUTO    = 2'h3;

   // Reset values
   localparam logic [7:0] RST_INT_ENABLE   = 8'h00;
   localparam logic [7:0] RST_MOTION_CTRL  = 8'h00;
   localparam logic [7:0] RST_QUEUE_CTRL   = 8'h00;
   localparam logic [5:0] RST_QUEUE_LEVEL  = 6'h10;
   localparam logic [7:0] RST_SERVICE_CTRL = 8'h01;
   localparam logic [2:0] RST_QUEUE_FLAGS  = 3'h1;

   // Queue size and timing
   localparam logic [5:0] QUEUE_DEPTH      = 6'h20;
   localparam int         CLK_HZ           = 40000000;
   localparam int         TEMP_LATCH_US    = 1000;
   localparam int         TEMP_LATCH_CYC   = (CLK_HZ / 1000000) * TEMP_LATCH_US;
endpackage : mfi_pkg
`default_nettype wire

// ==== tb/mfi_irq_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
module mfi_irq_properties #(
   parameter int TEMP_LATCH_CYCLES = 20
) (
   // Clock and reset
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        software_reset,
   // Register bus
   input wire logic [7:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] writedata,
   input wire logic [3:0]  byteenable,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   // Event sources
   input wire logic        tilt_cond,
   input wire logic        flip_cond,
   input wire logic        generic_movement_cond,
   input wire logic        shake_cond,
   input wire logic        steep_tilt_cond,
   input wire logic        z_process_done,
   input wire logic        sample_write,
   // Requests
   input wire logic        primary_irq_request,
   input wire logic        secondary_irq_request
);
   logic indiv_ff;
   logic rst_d_ff;
   wire  clr = write && byteenable[0] && address[7:2] == mfi_pkg::IDX_INT_STATUS;
   wire  ev  = z_process_done | tilt_cond | flip_cond | generic_movement_cond | shake_cond | steep_tilt_cond;
   wire  acc = sample_write | read;

   default clocking dc @(posedge clk); endclocking
   default disable iff (reset || software_reset || rst_d_ff);

   // $past values still show pre-reset outputs one edge after a reset pulse
   always_ff @(posedge clk)
   begin
      rst_d_ff <= reset | software_reset;
   end

   // Shadow of the clear mode, so clears can be judged from the ports alone
   always_ff @(posedge clk)
   begin
      if (reset || software_reset)
      begin
         indiv_ff <= 1'b0;
      end
      else if (write && byteenable[0] && address[7:2] == mfi_pkg::IDX_SERVICE_CTRL)
      begin
         indiv_ff <= writedata[mfi_pkg::BIT_INDIV_CLEAR];
      end
   end

   wr_no_wait_a: assert property (write |-> !waitrequest)
      else $error("write was made to wait");
   rd_one_wait_a: assert property ($rose(read) |-> waitrequest ##1 !waitrequest)
      else $error("read wait state count wrong");
   rd_hold_a: assert property (!(read && waitrequest) |=> $stable(readdata))
      else $error("read data changed without a read");
   rst_quiet_a: assert property ($fell(reset || software_reset) |-> !primary_irq_request && !secondary_irq_request)
      else $error("request high after reset");
   glob_clr_a: assert property (clr && !indiv_ff && !ev && !$past(ev) |=> !primary_irq_request)
      else $error("global clear left primary request");
   glob_q_clr_a: assert property (clr && !indiv_ff && !acc && !$past(acc) |=> !secondary_irq_request)
      else $error("global clear left queue request");
   indiv_q_clr_a: assert property (clr && indiv_ff && writedata[5] && !acc |=> !secondary_irq_request)
      else $error("queue group clear failed");
   q_latched_a: assert property (secondary_irq_request && !clr |=> secondary_irq_request)
      else $error("queue request dropped without clear");
   prim_cause_a: assert property ($rose(primary_irq_request) |-> $past(ev))
      else $error("primary request rose without event");
   sec_cause_a: assert property ($rose(secondary_irq_request) |-> $past(acc))
      else $error("queue request rose without access");
endmodule : mfi_irq_properties

bind mfi_irq_service mfi_irq_properties #(.TEMP_LATCH_CYCLES(TEMP_LATCH_CYCLES)) u_props (
   .clk, .reset, .software_reset, .address, .read, .write, .writedata, .byteenable, .readdata,
   .waitrequest, .tilt_cond, .flip_cond, .generic_movement_cond, .shake_cond, .steep_tilt_cond,
   .z_process_done, .sample_write, .primary_irq_request, .secondary_irq_request);
`default_nettype wire

// ==== tb/mfi_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module mfi_host (
   // Clock
   input  wire logic        clk,
   // Bus answers
   input  wire logic        waitrequest,
   input  wire logic [31:0] readdata,
   // Bus requests
   output logic [7:0]       address,
   output logic             read,
   output logic             write,
   output logic [31:0]      writedata,
   output logic [3:0]       byteenable
);
   initial
   begin
      address    = 8'h00;
      read       = 1'b0;
      write      = 1'b0;
      writedata  = 32'h0;
      byteenable = 4'hf;
   end

   // Callers enter just after a rising edge; one idle cycle follows each access
   task automatic wr(input logic [5:0] i, input logic [7:0] d);
      address   <= {i, 2'h0};
      writedata <= {24'h0, d};
      write     <= 1'b1;
      // The write lands at the rising edge where waitrequest is seen low
      do @(posedge clk); while (waitrequest !== 1'b0);
      write <= 1'b0;
      @(posedge clk);
   endtask : wr

   task automatic rd(input logic [5:0] i, output logic [7:0] d);
      address <= {i, 2'h0};
      read    <= 1'b1;
      // Read data is taken at the same edge that sees waitrequest low
      do @(posedge clk); while (waitrequest !== 1'b0);
      d = readdata[7:0];
      read <= 1'b0;
      @(posedge clk);
   endtask : rd
endmodule : mfi_host
`default_nettype wire

// ==== tb/mfi_irq_service_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin fail_count++; \
   $display("Error %s expected %h seen %h", n, e, a); end end
module mfi_irq_service_bench;
   localparam int         TL = 20;
   localparam logic [5:0] ST = mfi_pkg::IDX_INT_STATUS;
   localparam logic [5:0] QS = mfi_pkg::IDX_QUEUE_STATUS;
   localparam logic [5:0] QI = mfi_pkg::IDX_QUEUE_IRQ;
   localparam logic [5:0] SC = mfi_pkg::IDX_SERVICE_CTRL;
   localparam logic [5:0] MC = mfi_pkg::IDX_MOTION_CTRL;
   localparam logic [5:0] IE = mfi_pkg::IDX_INT_ENABLE;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        software_reset = 1'b0;
   logic [4:0]  cond = 5'h0;
   logic        motion_hw_clear = 1'b0;
   logic        z_process_done = 1'b0;
   logic        z_accum_start = 1'b0;
   logic        wake_state = 1'b1;
   logic        sample_write = 1'b0;
   logic [7:0]  sample_data = 8'h0;
   logic [7:0]  v;
   wire  [7:0]  address;
   wire         read;
   wire         write;
   wire  [31:0] writedata;
   wire  [3:0]  byteenable;
   wire  [31:0] readdata;
   wire         waitrequest;
   wire         pri;
   wire         sec;
   int          fail_count = 0;
   int          total_checks = 0;

   mfi_host u_host (.clk, .waitrequest, .readdata, .address, .read, .write, .writedata, .byteenable);

   mfi_irq_service #(.TEMP_LATCH_CYCLES(TL)) u_dut (
      .clk, .reset, .software_reset, .address, .read, .write, .writedata, .byteenable, .readdata,
      .waitrequest, .tilt_cond(cond[0]), .flip_cond(cond[1]), .generic_movement_cond(cond[2]),
      .shake_cond(cond[3]), .steep_tilt_cond(cond[4]), .motion_hw_clear, .z_process_done,
      .z_accum_start, .wake_state, .sample_write, .sample_data, .primary_irq_request(pri),
      .secondary_irq_request(sec));

   initial
   begin
      forever #12.5 clk = ~clk;
   end

   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test

   task automatic rchk(input string n, input logic [5:0] i, input logic [7:0] e);
      logic [7:0] d;
      u_host.rd(i, d);
      `CHK(n, e, d)
   endtask : rchk

   task automatic irq(input logic p, input logic s);
      @(negedge clk);
      `CHK("primary", p, pri)
      `CHK("secondary", s, sec)
      @(posedge clk);
   endtask : irq

   task automatic fire(input logic [4:0] c);
      cond <= c;
      repeat (2) @(posedge clk);
      cond <= 5'h0;
      repeat (2) @(posedge clk);
   endtask : fire

   task automatic push(input int n);
      repeat (n)
      begin
         sample_write <= 1'b1;
         sample_data  <= sample_data + 8'h1;
         @(posedge clk);
      end
      sample_write <= 1'b0;
      @(posedge clk);
   endtask : push

   task automatic t_defaults;
      rchk("queue status", QS, 8'h01);
      rchk("level", mfi_pkg::IDX_QUEUE_LEVEL, 8'h10);
      rchk("unmapped", 6'h3f, 8'h00);
      irq(1'b0, 1'b0);
      $display("defaults done");
   endtask : t_defaults

   task automatic t_motion;
      u_host.wr(IE, 8'h19);
      u_host.wr(MC, 8'h08);
      fire(5'h08);
      rchk("status", ST, 8'h00);
      u_host.wr(MC, 8'h0c);
      fire(5'h10);
      rchk("status", ST, 8'h00);
      fire(5'h08);
      rchk("status", ST, 8'h08);
      irq(1'b1, 1'b0);
      u_host.wr(MC, 8'h1d);
      fire(5'h11);
      rchk("status", ST, 8'h19);
      u_host.wr(ST, 8'h00);
      rchk("status", ST, 8'h00);
      irq(1'b0, 1'b0);
      $display("motion done");
   endtask : t_motion

   task automatic t_queue;
      u_host.wr(mfi_pkg::IDX_QUEUE_CTRL, 8'h27);
      u_host.wr(mfi_pkg::IDX_QUEUE_LEVEL, 8'h02);
      wake_state <= 1'b0;
      push(1);
      rchk("queue status", QS, 8'h01);
      wake_state <= 1'b1;
      push(1);
      rchk("queue status", QS, 8'h00);
      push(1);
      rchk("queue status", QS, 8'h04);
      irq(1'b0, 1'b1);
      push(30);
      rchk("queue status", QS, 8'h06);
      rchk("queue irq", QI, 8'h06);
      u_host.wr(SC, 8'h41);
      u_host.wr(ST, 8'hdf);
      rchk("queue irq", QI, 8'h06);
      u_host.wr(ST, 8'h20);
      rchk("queue irq", QI, 8'h00);
      repeat (32) u_host.rd(mfi_pkg::IDX_QUEUE_DATA, v);
      rchk("queue status", QS, 8'h01);
      rchk("queue irq", QI, 8'h05);
      u_host.wr(SC, 8'h01);
      u_host.wr(ST, 8'h5a);
      rchk("queue irq", QI, 8'h00);
      irq(1'b0, 1'b0);
      $display("queue done");
   endtask : t_queue

   task automatic t_modes;
      u_host.wr(SC, 8'h02);
      fire(5'h08);
      irq(1'b1, 1'b0);
      repeat (TL) @(posedge clk);
      irq(1'b0, 1'b0);
      fire(5'h08);
      u_host.wr(ST, 8'h00);
      irq(1'b0, 1'b0);
      u_host.wr(SC, 8'h03);
      u_host.wr(IE, 8'h99);
      cond <= 5'h08;
      repeat (3) @(posedge clk);
      irq(1'b1, 1'b0);
      cond <= 5'h00;
      repeat (2) @(posedge clk);
      irq(1'b0, 1'b0);
      fire(5'h08);
      cond <= 5'h08;
      repeat (3) @(posedge clk);
      motion_hw_clear <= 1'b1;
      @(posedge clk);
      motion_hw_clear <= 1'b0;
      repeat (2) @(posedge clk);
      irq(1'b0, 1'b0);
      cond <= 5'h00;
      z_process_done <= 1'b1;
      @(posedge clk);
      z_process_done <= 1'b0;
      repeat (2) @(posedge clk);
      rchk("status", ST, 8'h80);
      z_accum_start <= 1'b1;
      @(posedge clk);
      z_accum_start <= 1'b0;
      repeat (2) @(posedge clk);
      irq(1'b0, 1'b0);
      $display("modes done");
   endtask : t_modes

   initial
   begin
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      t_defaults();
      t_motion();
      t_queue();
      t_modes();
      push(3);
      software_reset <= 1'b1;
      @(posedge clk);
      software_reset <= 1'b0;
      t_defaults();
      stop_test();
   end

   // Whole run needs well under 2000 cycles
   initial
   begin
      repeat (20000) @(posedge clk);
      fail_count++;
      stop_test();
   end
endmodule : mfi_irq_service_bench
`default_nettype wire
